// ===== logic/pusc_strap_capture.sv
// power-up strap capture: samples the memory address lines when the chip
// reset pin rises, holds the decoded settings and then hands the pins to
// the dram address path; also makes the main and the late cpu reset
// assumes the chip reset pin and the strap pins are asynchronous to i_clock
// and that board straps stay stable until the device drives the lines
//
// Behaviour
// - two straps decode host frequency select
// - queue strap picks four or one level
// - clock strap picks plls or external clocks
// - graphics test strap high means test mode
// - gtl pullups on when strap low
// - pci strap picks 33 or 66 MHz
// - graphics interrupt enabled when strap low
// - graphics io decode enabled when strap low
// - base strap picks address map zero/one
// - four panel straps form panel code
// - unfitted straps read zero, board pulls
// - base strap high clears interrupt config bit
// - lines input while sampling, then dram outputs
// - late cpu reset trails by two clocks
// - sample at reset rise, defaults while asserted
`include "pusc_map.svh"
module pusc_strap_capture (
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  // chip reset pin, active low
  input  wire logic              i_chip_reset_n,
  // memory address pins
  input  wire pusc_pkg::pusc_ma_t i_ma,
  output pusc_pkg::pusc_ma_t     o_ma,
  output pusc_pkg::pusc_ma_t     o_ma_oe,
  // dram address path
  input  wire pusc_pkg::pusc_ma_t i_dram_addr,
  input  wire logic [1:0]        i_dram_bank,
  // cpu reset
  input  wire logic              i_cpu_reset_req,
  output logic                   o_cpu_reset_out_n,
  output logic                   o_cpu_reset_late_n,
  // graphics interrupt
  input  wire logic              i_gfx_irq_req,
  input  wire logic              i_pci_config_phase,
  output logic                   o_gfx_irq_req,
  output logic                   o_gfx_irq_config_bit,
  // decoded settings
  output pusc_pkg::pusc_freq_e   o_host_freq,
  output logic                   o_queue_one_level,
  output logic                   o_clock_external,
  output logic                   o_gfx_test_mode,
  output logic                   o_gtl_pullup_en,
  output logic                   o_pci_66mhz,
  output logic                   o_gfx_irq_en,
  output logic                   o_gfx_io_en,
  output logic                   o_gfx_base_map1,
  output logic [3:0]             o_panel_type,
  output logic                   o_straps_valid
);
  import pusc_pkg::*;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // three stages; a change counts once stages two and three agree
  logic      crst_s1_ff;
  logic      crst_s2_ff;
  logic      crst_s3_ff;
  logic      crst_level_ff;
  pusc_ma_t  ma_s1_ff;
  pusc_ma_t  ma_s2_ff;
  pusc_ma_t  ma_s3_ff;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      crst_s1_ff <= 1'b0;
      crst_s2_ff <= 1'b0;
      crst_s3_ff <= 1'b0;
    end else begin
      crst_s1_ff <= i_chip_reset_n;
      crst_s2_ff <= crst_s1_ff;
      crst_s3_ff <= crst_s2_ff;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ma_s1_ff <= `PUSC_MA_RST;
      ma_s2_ff <= `PUSC_MA_RST;
      ma_s3_ff <= `PUSC_MA_RST;
    end else begin
      ma_s1_ff <= i_ma;
      ma_s2_ff <= ma_s1_ff;
      ma_s3_ff <= ma_s2_ff;
    end
  end

  // filtered chip reset level, starts asserted
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      crst_level_ff <= 1'b0;
    end else if (crst_s2_ff == crst_s3_ff) begin
      crst_level_ff <= crst_s3_ff;
    end
  end

  logic crst_rise;
  logic crst_low;

  assign crst_rise = (crst_s2_ff == crst_s3_ff) && crst_s3_ff &&
                     !crst_level_ff;
  assign crst_low  = !crst_level_ff;

  // ----------------------------------------------------------------------
  // capture sequence
  // ----------------------------------------------------------------------
  pusc_state_e state_ff;
  pusc_state_e nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PUSC_ST_HOLD: begin
        if (crst_rise) begin
          nxt_state = PUSC_ST_SAMPLE;
        end
      end
      PUSC_ST_SAMPLE: begin
        nxt_state = PUSC_ST_RUN;
      end
      PUSC_ST_RUN: begin
        if (crst_low) begin
          nxt_state = PUSC_ST_HOLD;
        end
      end
      default: begin
        nxt_state = PUSC_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_ff <= PUSC_ST_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // sample pulse: the strap levels seen when the pin rose are still in
  // stage three, since the board does not move them until we drive
  logic take_straps;
  logic clear_straps;

  assign take_straps  = (state_ff == PUSC_ST_SAMPLE);
  assign clear_straps = (state_ff == PUSC_ST_HOLD) && crst_low;

  // ----------------------------------------------------------------------
  // strap latches
  // ----------------------------------------------------------------------
  logic       freq_msb_ff;
  logic       freq_lsb_ff;
  logic       queue_depth_ff;
  logic       clock_src_ff;
  logic       gfx_test_ff;
  logic       gtl_pull_ff;
  logic       pci_freq_ff;
  logic       gfx_irq_ff;
  logic       gfx_io_ff;
  logic       gfx_base_ff;
  logic [3:0] panel_ff;
  logic       valid_ff;

  // an unfitted line reads low, so the reset default is zero
  always_ff @(posedge i_clock) begin
    if (i_reset || clear_straps) begin
      freq_msb_ff    <= `PUSC_STRAP_RST;
      freq_lsb_ff    <= `PUSC_STRAP_RST;
      queue_depth_ff <= `PUSC_STRAP_RST;
      clock_src_ff   <= `PUSC_STRAP_RST;
      gfx_test_ff    <= `PUSC_STRAP_RST;
      gtl_pull_ff    <= `PUSC_STRAP_RST;
      pci_freq_ff    <= `PUSC_STRAP_RST;
      gfx_irq_ff     <= `PUSC_STRAP_RST;
      gfx_io_ff      <= `PUSC_STRAP_RST;
      gfx_base_ff    <= `PUSC_STRAP_RST;
    end else if (take_straps) begin
      freq_msb_ff    <= ma_s3_ff[`PUSC_POS_FREQ_MSB];
      freq_lsb_ff    <= ma_s3_ff[`PUSC_POS_FREQ_LSB];
      queue_depth_ff <= ma_s3_ff[`PUSC_POS_QUEUE_DEPTH];
      clock_src_ff   <= ma_s3_ff[`PUSC_POS_CLOCK_SRC];
      gfx_test_ff    <= ma_s3_ff[`PUSC_POS_GFX_TEST];
      gtl_pull_ff    <= ma_s3_ff[`PUSC_POS_GTL_PULL];
      pci_freq_ff    <= ma_s3_ff[`PUSC_POS_PCI_FREQ];
      gfx_irq_ff     <= ma_s3_ff[`PUSC_POS_GFX_IRQ];
      gfx_io_ff      <= ma_s3_ff[`PUSC_POS_GFX_IO];
      gfx_base_ff    <= ma_s3_ff[`PUSC_POS_GFX_BASE];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset || clear_straps) begin
      panel_ff <= `PUSC_PANEL_RST;
    end else if (take_straps) begin
      panel_ff <= {ma_s3_ff[`PUSC_POS_PANEL_3],
                   ma_s3_ff[`PUSC_POS_PANEL_2],
                   ma_s3_ff[`PUSC_POS_PANEL_1],
                   ma_s3_ff[`PUSC_POS_PANEL_0]};
    end
  end

  // settings stay frozen while running; only i_reset or a new chip reset clears them
  always_ff @(posedge i_clock) begin
    if (i_reset || clear_straps) begin
      valid_ff <= 1'b0;
    end else if (take_straps) begin
      valid_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // decoded settings
  // ----------------------------------------------------------------------
  always_comb begin
    case ({freq_msb_ff, freq_lsb_ff})
      `PUSC_FREQ_CODE_66:   o_host_freq = PUSC_FREQ_66;
      `PUSC_FREQ_CODE_100:  o_host_freq = PUSC_FREQ_100;
      `PUSC_FREQ_CODE_AUTO: o_host_freq = PUSC_FREQ_AUTO;
      `PUSC_FREQ_CODE_133:  o_host_freq = PUSC_FREQ_133;
      default:              o_host_freq = PUSC_FREQ_66;
    endcase
  end

  assign o_queue_one_level = queue_depth_ff;
  assign o_clock_external  = clock_src_ff;
  assign o_gfx_test_mode   = gfx_test_ff;
  assign o_gtl_pullup_en   = !gtl_pull_ff;
  assign o_pci_66mhz       = pci_freq_ff;
  assign o_gfx_irq_en      = !gfx_irq_ff;
  assign o_gfx_io_en       = !gfx_io_ff;
  assign o_gfx_base_map1   = gfx_base_ff;
  assign o_panel_type      = panel_ff;
  assign o_straps_valid    = valid_ff;

  // ----------------------------------------------------------------------
  // graphics interrupt configuration bit
  // ----------------------------------------------------------------------
  logic irq_cfg_ff;
  logic irq_out_ff;

  // set by default, cleared at capture when the base strap is high
  always_ff @(posedge i_clock) begin
    if (i_reset || clear_straps) begin
      irq_cfg_ff <= 1'b1;
    end else if (take_straps) begin
      irq_cfg_ff <= !ma_s3_ff[`PUSC_POS_GFX_BASE];
    end
  end

  // a cleared bit keeps the request quiet during pci configuration
  always_ff @(posedge i_clock) begin
    if (i_reset || !valid_ff) begin
      irq_out_ff <= 1'b0;
    end else begin
      irq_out_ff <= i_gfx_irq_req && !gfx_irq_ff &&
                    !(i_pci_config_phase && !irq_cfg_ff);
    end
  end

  assign o_gfx_irq_config_bit = irq_cfg_ff;
  assign o_gfx_irq_req        = irq_out_ff;

  // ----------------------------------------------------------------------
  // memory address pin drive
  // ----------------------------------------------------------------------
  pusc_ma_t ma_out_ff;
  pusc_ma_t ma_oe_ff;
  pusc_ma_t nxt_ma_out;

  always_comb begin
    nxt_ma_out = i_dram_addr;
    nxt_ma_out[`PUSC_POS_BANK_1] = i_dram_bank[1];
    nxt_ma_out[`PUSC_POS_BANK_0] = i_dram_bank[0];
  end

  // lines stay inputs until the straps are held, so the board pulls win
  always_ff @(posedge i_clock) begin
    if (i_reset || !valid_ff) begin
      ma_oe_ff  <= `PUSC_MA_OE_OFF;
      ma_out_ff <= `PUSC_MA_RST;
    end else begin
      ma_oe_ff  <= `PUSC_MA_OE_ON;
      ma_out_ff <= nxt_ma_out;
    end
  end

  assign o_ma    = ma_out_ff;
  assign o_ma_oe = ma_oe_ff;

  // ----------------------------------------------------------------------
  // cpu reset pair
  // ----------------------------------------------------------------------
  logic cpu_rst_n_ff;

  // cpu held in reset until the settings it depends on are known
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cpu_rst_n_ff <= 1'b0;
    end else begin
      cpu_rst_n_ff <= valid_ff && !crst_low && !i_cpu_reset_req;
    end
  end

  pusc_rst_if rst_bus ();

  assign rst_bus.cpu_rst_n = cpu_rst_n_ff;

  pusc_reset_delay u_reset_delay (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .rst     (rst_bus.dly)
  );

  assign o_cpu_reset_out_n  = cpu_rst_n_ff;
  assign o_cpu_reset_late_n = rst_bus.cpu_rst_late_n;

endmodule

// ===== logic/pusc_map.svh
// offsets, field positions, reset values and counts of the strap capture
// assumes inclusion by bare name from the package and the top module
`ifndef PUSC_MAP_SVH
`define PUSC_MAP_SVH

// ----------------------------------------------------------------------
// memory address pin group
// ----------------------------------------------------------------------
`define PUSC_MA_WIDTH        15
`define PUSC_MA_RST          15'h0000
`define PUSC_MA_OE_ON        15'h7fff
`define PUSC_MA_OE_OFF       15'h0000

// ----------------------------------------------------------------------
// strap positions on the memory address lines
// ----------------------------------------------------------------------
`define PUSC_POS_FREQ_LSB    12
`define PUSC_POS_QUEUE_DEPTH 11
`define PUSC_POS_CLOCK_SRC   9
`define PUSC_POS_FREQ_MSB    8
`define PUSC_POS_GFX_TEST    7
`define PUSC_POS_GTL_PULL    6
`define PUSC_POS_PCI_FREQ    5
`define PUSC_POS_GFX_IRQ     4
`define PUSC_POS_GFX_IO      3
`define PUSC_POS_GFX_BASE    2
`define PUSC_POS_PANEL_3     14
`define PUSC_POS_PANEL_2     13
`define PUSC_POS_PANEL_1     1
`define PUSC_POS_PANEL_0     0
`define PUSC_POS_BANK_1      12
`define PUSC_POS_BANK_0      11

// ----------------------------------------------------------------------
// host frequency codes and reset values
// ----------------------------------------------------------------------
`define PUSC_FREQ_CODE_66    2'h0
`define PUSC_FREQ_CODE_100   2'h1
`define PUSC_FREQ_CODE_AUTO  2'h2
`define PUSC_FREQ_CODE_133   2'h3
`define PUSC_STRAP_RST       1'h0
`define PUSC_PANEL_RST       4'h0

// ----------------------------------------------------------------------
// cpu reset delay in host clock periods
// ----------------------------------------------------------------------
`define PUSC_CPU_RST_DLY     2

`endif

// ===== logic/pusc_pkg.sv
// types shared by the strap capture modules
// assumes the map header is on the include path
`include "pusc_map.svh"

package pusc_pkg;

  // ----------------------------------------------------------------------
  // host frequency selection
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PUSC_FREQ_66   = `PUSC_FREQ_CODE_66,
    PUSC_FREQ_100  = `PUSC_FREQ_CODE_100,
    PUSC_FREQ_AUTO = `PUSC_FREQ_CODE_AUTO,
    PUSC_FREQ_133  = `PUSC_FREQ_CODE_133
  } pusc_freq_e;

  // ----------------------------------------------------------------------
  // capture sequence
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PUSC_ST_HOLD,
    PUSC_ST_SAMPLE,
    PUSC_ST_RUN
  } pusc_state_e;

  typedef logic [`PUSC_MA_WIDTH-1:0] pusc_ma_t;

endpackage

// ===== logic/pusc_rst_if.sv
// carrier between the strap capture top and its cpu reset delay line
// assumes both ends sit on the same clock
interface pusc_rst_if;
  logic cpu_rst_n;
  logic cpu_rst_late_n;

  modport src (
    output cpu_rst_n,
    input  cpu_rst_late_n
  );

  modport dly (
    input  cpu_rst_n,
    output cpu_rst_late_n
  );
endinterface

// ===== logic/pusc_reset_delay.sv
// delay line that makes the late cpu reset from the main cpu reset
// assumes i_clock is the host clock and i_reset is synchronous
`include "pusc_map.svh"
module pusc_reset_delay (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_reset,
  // reset pair
  pusc_rst_if.dly   rst
);
  import pusc_pkg::*;

  // ----------------------------------------------------------------------
  // shift stages, all asserted (low) under reset
  // ----------------------------------------------------------------------
  // unpacked, so that each stage is its own variable for its own process
  logic stage_ff [`PUSC_CPU_RST_DLY];

  generate
    for (genvar g = 0; g < `PUSC_CPU_RST_DLY; g++) begin : g_stage
      always_ff @(posedge i_clock) begin
        if (i_reset) begin
          stage_ff[g] <= 1'b0;
        end else if (g == 0) begin
          stage_ff[g] <= rst.cpu_rst_n;
        end else begin
          stage_ff[g] <= stage_ff[(g == 0) ? 0 : g-1];
        end
      end
    end
  endgenerate

  assign rst.cpu_rst_late_n = stage_ff[`PUSC_CPU_RST_DLY-1];
endmodule

// ===== sim/pusc_strap_board.sv
// board model: strap resistors on the memory address lines
// assumes the device releases a line while its output enable is low
module pusc_strap_board (
  // fitted resistors, 1 = pull-up fitted
  input  wire pusc_pkg::pusc_ma_t i_fit,
  // device drive
  input  wire pusc_pkg::pusc_ma_t i_drive,
  input  wire pusc_pkg::pusc_ma_t i_oe,
  // resolved pin levels
  output pusc_pkg::pusc_ma_t      o_pins
);
  import pusc_pkg::*;
  // ----------------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------------
  // an unfitted line sits on the weak default pull-down, so it reads 0
  always_comb begin
    for (int b = 0; b < 15; b++) begin
      o_pins[b] = i_oe[b] ? i_drive[b] : i_fit[b];
    end
  end
endmodule

// ===== sim/pusc_strap_capture_props.sv
// assertions on the strap capture ports
// assumes a bind onto pusc_strap_capture and a single clock domain
module pusc_strap_capture_props (
  // clock and reset
  input wire logic                i_clock,
  input wire logic                i_reset,
  // pins
  input wire pusc_pkg::pusc_ma_t  i_ma,
  input wire pusc_pkg::pusc_ma_t  o_ma_oe,
  // cpu reset
  input wire logic                i_cpu_reset_req,
  input wire logic                o_cpu_reset_out_n,
  input wire logic                o_cpu_reset_late_n,
  // graphics interrupt
  input wire logic                i_gfx_irq_req,
  input wire logic                i_pci_config_phase,
  input wire logic                o_gfx_irq_req,
  input wire logic                o_gfx_irq_config_bit,
  // settings
  input wire pusc_pkg::pusc_freq_e o_host_freq,
  input wire logic                o_queue_one_level,
  input wire logic                o_clock_external,
  input wire logic                o_gfx_test_mode,
  input wire logic                o_gtl_pullup_en,
  input wire logic                o_pci_66mhz,
  input wire logic                o_gfx_irq_en,
  input wire logic                o_gfx_io_en,
  input wire logic                o_gfx_base_map1,
  input wire logic [3:0]          o_panel_type,
  input wire logic                o_straps_valid
);
  import pusc_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // ----------------------------------------------------------------------
  // decode at capture; straps are still on the pins the edge before
  // ----------------------------------------------------------------------
  chk_freq_decode: assert property ($rose(o_straps_valid) |->
    o_host_freq == {$past(i_ma[8]), $past(i_ma[12])})
    else $error("host frequency decode wrong");
  chk_queue_clock: assert property ($rose(o_straps_valid) |->
    o_queue_one_level == $past(i_ma[11]) &&
    o_clock_external == $past(i_ma[9])) else $error("queue or clock wrong");
  chk_test_gtl: assert property ($rose(o_straps_valid) |->
    o_gfx_test_mode == $past(i_ma[7]) && o_gtl_pullup_en == !$past(i_ma[6]))
    else $error("test mode or pullup wrong");
  chk_pci_irq: assert property ($rose(o_straps_valid) |->
    o_pci_66mhz == $past(i_ma[5]) && o_gfx_irq_en == !$past(i_ma[4]))
    else $error("pci rate or irq enable wrong");
  chk_io_base_panel: assert property ($rose(o_straps_valid) |->
    o_gfx_io_en == !$past(i_ma[3]) && o_gfx_base_map1 == $past(i_ma[2]) &&
    o_panel_type == {$past(i_ma[14]), $past(i_ma[13]), $past(i_ma[1]),
    $past(i_ma[0])}) else $error("io, base map or panel wrong");
  // ----------------------------------------------------------------------
  // after capture, plus pins released before capture and late reset timing
  // ----------------------------------------------------------------------
  chk_cfg_bit: assert property (o_straps_valid |->
    o_gfx_irq_config_bit == !o_gfx_base_map1) else $error("config bit wrong");
  chk_irq_gate: assert property (
    o_gfx_irq_req == ($past(o_straps_valid) && $past(i_gfx_irq_req) &&
    $past(o_gfx_irq_en) && !($past(i_pci_config_phase) &&
    !$past(o_gfx_irq_config_bit)))) else $error("irq gating wrong");
  chk_pins_driven: assert property ($rose(o_straps_valid) |=>
    o_ma_oe == 15'h7fff) else $error("pins not driven after capture");
  chk_pins_input: assert property (
    !o_straps_valid && !$past(o_straps_valid) |-> o_ma_oe == 15'h0000)
    else $error("pins driven while sampling");
  chk_late_reset: assert property (
    o_cpu_reset_late_n == $past(o_cpu_reset_out_n, 2))
    else $error("late cpu reset not two clocks behind");
  chk_cpu_release: assert property ($rose(o_cpu_reset_out_n) |->
    $past(o_straps_valid) && !$past(i_cpu_reset_req))
    else $error("cpu reset released early");
  chk_settings_held: assert property (
    o_straps_valid && $past(o_straps_valid) |-> $stable(o_host_freq) &&
    $stable(o_panel_type) && $stable(o_pci_66mhz))
    else $error("settings changed while latched");
endmodule

bind pusc_strap_capture pusc_strap_capture_props u_props (
  .i_clock(i_clock), .i_reset(i_reset), .i_ma(i_ma), .o_ma_oe(o_ma_oe),
  .i_cpu_reset_req(i_cpu_reset_req), .o_cpu_reset_out_n(o_cpu_reset_out_n),
  .o_cpu_reset_late_n(o_cpu_reset_late_n), .i_gfx_irq_req(i_gfx_irq_req),
  .i_pci_config_phase(i_pci_config_phase), .o_gfx_irq_req(o_gfx_irq_req),
  .o_gfx_irq_config_bit(o_gfx_irq_config_bit), .o_host_freq(o_host_freq),
  .o_queue_one_level(o_queue_one_level), .o_clock_external(o_clock_external),
  .o_gfx_test_mode(o_gfx_test_mode), .o_gtl_pullup_en(o_gtl_pullup_en),
  .o_pci_66mhz(o_pci_66mhz), .o_gfx_irq_en(o_gfx_irq_en),
  .o_gfx_io_en(o_gfx_io_en), .o_gfx_base_map1(o_gfx_base_map1),
  .o_panel_type(o_panel_type), .o_straps_valid(o_straps_valid));

// ===== sim/tb_top.sv
// self-checking bench for the strap capture
// assumes the board model and the checker are compiled before it
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pusc_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, chip_n = 1'b0;
  logic       cpu_req = 1'b0, irq_req = 1'b0, phase = 1'b0;
  logic [1:0] bank = 2'h0;
  pusc_ma_t   fit = 15'h0000, addr = 15'h0000, ma, o_ma, oe;
  logic       rst_n, late_n, irq, cfg, q1, ext, tst, gtl, p66, ien, ioen, b1;
  logic       valid;
  logic [3:0] panel;
  pusc_freq_e freq;
  int         fails = 0, n_tests = 0, cycles = 0;
  pusc_ma_t   tbl [8] = '{15'h0000, 15'h7fff, 15'h1000, 15'h0100, 15'h1100,
                          15'h2a54, 15'h55ab, 15'h0004};

  always #20 clk = ~clk;

  pusc_strap_board u_board (.i_fit(fit), .i_drive(o_ma), .i_oe(oe),
    .o_pins(ma));
  pusc_strap_capture uut (.i_clock(clk), .i_reset(rst),
    .i_chip_reset_n(chip_n), .i_ma(ma), .o_ma(o_ma), .o_ma_oe(oe),
    .i_dram_addr(addr), .i_dram_bank(bank),
    .i_cpu_reset_req(cpu_req), .o_cpu_reset_out_n(rst_n),
    .o_cpu_reset_late_n(late_n), .i_gfx_irq_req(irq_req),
    .i_pci_config_phase(phase), .o_gfx_irq_req(irq), .o_gfx_irq_config_bit(cfg),
    .o_host_freq(freq), .o_queue_one_level(q1), .o_clock_external(ext),
    .o_gfx_test_mode(tst), .o_gtl_pullup_en(gtl), .o_pci_66mhz(p66),
    .o_gfx_irq_en(ien), .o_gfx_io_en(ioen), .o_gfx_base_map1(b1),
    .o_panel_type(panel), .o_straps_valid(valid));
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // pin low long enough for the synchroniser, then a clean rise
  task automatic capture(input pusc_ma_t s);
    chip_n = 1'b0;
    step(8);
    fit = s;
    step(2);
    chip_n = 1'b1;
    for (int i = 0; i < 20 && valid !== 1'b1; i++) step(1);
    check(16'(valid), 16'h0001);
    check(16'(freq), 16'({s[8], s[12]}));
    check(16'(q1), 16'(s[11]));
    check(16'(ext), 16'(s[9]));
    check(16'(tst), 16'(s[7]));
    check(16'(gtl), 16'(!s[6]));
    check(16'(p66), 16'(s[5]));
    check(16'(ien), 16'(!s[4]));
    check(16'(ioen), 16'(!s[3]));
    check(16'(b1), 16'(s[2]));
    check(16'(panel), 16'({s[14], s[13], s[1], s[0]}));
    check(16'(cfg), 16'(!s[2]));
  endtask
  task automatic check_defaults;
    check(16'({valid, rst_n, cfg}), 16'h0001);
    check(16'(oe), 16'h0000);
    check(16'({freq, panel}), 16'h0000);
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic test_strap_table;
    foreach (tbl[i]) capture(tbl[i]);
  endtask
  task automatic test_hold_and_drive;
    capture(15'h3b6d);
    fit = 15'h4492;
    addr = 15'h5a3c;
    bank = 2'h2;
    step(20);
    // straps of 15'h3b6d: host freq code 3, panel code 5
    check(16'({freq, panel}), 16'h0035);
    check(16'(o_ma), 16'({addr[14:13], bank, addr[10:0]}));
    check(16'(ma), 16'({addr[14:13], bank, addr[10:0]}));
  endtask
  task automatic test_cpu_reset;
    step(4);
    check(16'({rst_n, late_n}), 16'h0003);
    cpu_req = 1'b1;
    for (int i = 0; i < 10 && rst_n !== 1'b0; i++) step(1);
    check(16'({rst_n, late_n}), 16'h0001);
    step(1);
    check(16'(late_n), 16'h0001);
    step(1);
    check(16'(late_n), 16'h0000);
    cpu_req = 1'b0;
    step(6);
    check(16'({rst_n, late_n}), 16'h0003);
  endtask
  task automatic test_irq;
    capture(15'h0004);
    irq_req = 1'b1;
    phase = 1'b1;
    step(2);
    check(16'(irq), 16'h0000);
    phase = 1'b0;
    step(2);
    check(16'(irq), 16'h0001);
    capture(15'h0010);
    step(2);
    check(16'(irq), 16'h0000);
    capture(15'h0000);
    phase = 1'b1;
    step(2);
    check(16'(irq), 16'h0001);
    irq_req = 1'b0;
    phase = 1'b0;
  endtask
  task automatic test_defaults;
    capture(15'h7fff);
    chip_n = 1'b0;
    step(8);
    check_defaults();
    capture(15'h7fff);
    rst = 1'b1;
    step(3);
    rst = 1'b0;
    step(1);
    check_defaults();
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    step(3);
    rst = 1'b0;
    test_strap_table();
    test_hold_and_drive();
    test_cpu_reset();
    test_irq();
    test_defaults();
    complete_run();
  end
endmodule
